// file: lkog_top.sv
// Keepalive timing, special output gating, status view and register slave.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// [RL1] The five special outputs are active only while keepalive is held.
// [RL2] A keepalive bit sets a steady keepalive output, not a pulse.
// [RL3] Central must send the keepalive bit in every command message.
// [RL4] Keepalive drops after more than 3.0 s without a set keepalive bit.
// [RL5] A menu selection shows the fourteen function states.
// [RL6] The view follows each function without added delay.
// [RL7] The send indicator is transmitter active AND clear to send.
// [RL8] On keepalive loss all commands drop and standby takes over; a message in the loss cycle loads its commands instead.
// [RL9] The loss timer restarts on each valid keepalive message.
module lkog_top
  import lkog_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        msg_valid_i,
  input  wire lkog_cmd_t   msg_cmd_i,
  input  wire logic        tx_active_i,
  input  wire logic        cts_i,
  input  wire logic        carrier_i,
  output logic             keepalive_o,
  output lkog_spec_t       spec_o,
  output logic             standby_o,
  output logic             rts_o,
  output lkog_view_t       view_o,
  output logic             irq_o
);

  // Pin synchronisers.
  logic       cts_m;
  logic       cts_s;
  logic       cd_m;
  logic       cd_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cts_m <= 1'b0;
      cts_s <= 1'b0;
      cd_m  <= 1'b0;
      cd_s  <= 1'b0;
    end
    else
    begin
      cts_m <= cts_i;
      cts_s <= cts_m;
      cd_m  <= carrier_i;
      cd_s  <= cd_m;
    end
  end

  // Keepalive loss timer.
  logic        ka_msg;
  logic        ka_loss;
  logic        tick;
  logic [31:0] pre_cnt;
  logic [15:0] tick_cnt;
  lkog_cmd_t   cmd;

  assign ka_msg  = msg_valid_i && msg_cmd_i.line_keepalive_cmd;
  assign tick    = (pre_cnt == TICK_LEN - 1);
  assign ka_loss = keepalive_o && !ka_msg && tick
                   && (tick_cnt == 16'(LOSS_TICKS));

  // [RL9] Restarting time base.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ka_msg || tick)
      pre_cnt <= 32'h0;
    else
      pre_cnt <= pre_cnt + 32'h1;
  end

  // [RL9] Tick count restarts.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ka_msg || !keepalive_o)
      tick_cnt <= 16'h0;
    else if (tick && tick_cnt != 16'hffff)
      tick_cnt <= tick_cnt + 16'h1;
  end

  // [RL2] Steady keepalive state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      keepalive_o <= 1'b0;
    else if (ka_msg)
      keepalive_o <= 1'b1;
    // [RL4] Timeout drops keepalive.
    else if (ka_loss)
      keepalive_o <= 1'b0;
  end

  // Command latch; a lost keepalive clears every command unless a message arrives in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmd <= '0;
    else if (msg_valid_i)
      cmd <= msg_cmd_i;
    // [RL8] Drop all commands.
    else if (ka_loss)
      cmd <= '0;
  end

  // Registers written by software.
  logic              menu_sel;
  logic [IRQ_W-1:0]  irq_en;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_evt;
  logic              wr;
  logic              ka_gain;

  // A write lands at the edge at which the master samples ack high.
  assign wr      = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign ka_gain = ka_msg && !keepalive_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      menu_sel <= CTRL_RST;
      irq_en   <= IEN_RST;
    end
    else if (wr && adr_i == ADR_CTRL)
      menu_sel <= dat_i[CTRL_MENU];
    else if (wr && adr_i == ADR_IEN)
      irq_en <= dat_i[IRQ_W-1:0];
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always_comb
  begin
    irq_evt           = '0;
    irq_evt[IRQ_MSG]  = msg_valid_i;
    irq_evt[IRQ_GAIN] = ka_gain;
    irq_evt[IRQ_LOSS] = ka_loss;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat <= '0;
    else if (wr && adr_i == ADR_ICLR)
      irq_stat <= (irq_stat & ~dat_i[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat <= irq_stat | irq_evt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((irq_stat | irq_evt) & irq_en);
  end

  // Output gating and view, all taken from next-state values.
  logic       next_ka;
  lkog_cmd_t  next_cmd;
  lkog_spec_t next_spec;
  lkog_view_t next_view;
  logic       next_rts;

  assign next_ka  = ka_msg || (keepalive_o && !ka_loss);
  assign next_cmd = msg_valid_i ? msg_cmd_i : (ka_loss ? '0 : cmd);
  // [RL7] Send indicator AND term.
  assign next_rts = tx_active_i && cts_s;

  // [RL1] Gate by keepalive.
  always_comb
  begin
    next_spec.plan_release        = next_cmd.plan_release && next_ka;
    next_spec.coord_yield_request = next_cmd.coord_yield_request && next_ka;
    next_spec.force_off_first     = next_cmd.force_off_first && next_ka;
    next_spec.force_off_second    = next_cmd.force_off_second && next_ka;
    next_spec.phase_skip_cmd      = next_cmd.phase_skip_cmd && next_ka;
  end

  // [RL5] Fourteen-function view.
  always_comb
  begin
    next_view.line_keepalive       = next_ka;
    next_view.coord_yield_request  = next_cmd.coord_yield_request;
    next_view.force_off_first      = next_cmd.force_off_first;
    next_view.force_off_second     = next_cmd.force_off_second;
    next_view.demand_all           = next_cmd.demand_all;
    next_view.plan_release         = next_cmd.plan_release;
    next_view.walker_demand        = next_cmd.walker_demand;
    next_view.phase_skip_status    = next_cmd.phase_skip_cmd;
    next_view.request_to_send      = next_rts;
    next_view.carrier_detect       = cd_s;
    next_view.uncoord_run          = next_cmd.uncoord_run;
    next_view.special_function_one = next_cmd.special_function_one;
    next_view.special_function_two = next_cmd.special_function_two;
    next_view.blink_mode           = next_cmd.blink_mode;
  end

  lkog_view_t live_view;

  // [RL6] Registered each cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      spec_o    <= '0;
      rts_o     <= 1'b0;
      standby_o <= 1'b1;
      live_view <= '0;
      view_o    <= '0;
    end
    else
    begin
      spec_o    <= next_spec;
      rts_o     <= next_rts;
      // [RL8] Standby while keepalive is down.
      standby_o <= !next_ka;
      live_view <= next_view;
      view_o    <= menu_sel ? next_view : '0;
    end
  end

  // Wishbone classic answer: ack one cycle after the request appears.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (cyc_i && stb_i && !we_i && !ack_o)
    begin
      unique case (adr_i)
        ADR_CTRL:  dat_o <= {31'h0, menu_sel};
        ADR_VIEW:  dat_o <= {18'h0, live_view};
        ADR_ISTAT: dat_o <= {29'h0, irq_stat};
        ADR_IEN:   dat_o <= {29'h0, irq_en};
        default:   dat_o <= 32'h0;
      endcase
    end
  end

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic past_ok;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      past_ok <= 1'b0;
    else
      past_ok <= 1'b1;
  end

  sequence s_ka_msg;
    msg_valid_i && msg_cmd_i.line_keepalive_cmd;
  endsequence

  sequence s_timeout;
    keepalive_o && tick && tick_cnt == 16'(LOSS_TICKS) && !ka_msg;
  endsequence

  a_spec_gated: assert property ( // [RL1]
    !keepalive_o |-> spec_o == '0)
    else $error("special output active without keepalive");

  a_ka_rises: assert property ( // [RL2]
    s_ka_msg |=> keepalive_o ##1 keepalive_o)
    else $error("keepalive not held after keepalive message");

  a_ka_timeout: assert property ( // [RL4]
    s_timeout |=> !keepalive_o && standby_o)
    else $error("keepalive not dropped at timeout");

  a_ka_stays: assert property ( // [RL4]
    keepalive_o && !(tick && tick_cnt == 16'(LOSS_TICKS)) |=> keepalive_o)
    else $error("keepalive dropped early");

  a_view_menu: assert property ( // [RL5]
    past_ok && !$past(menu_sel) |-> view_o == '0)
    else $error("view shown without menu selection");

  a_view_track: assert property ( // [RL6]
    menu_sel ##1 menu_sel |-> view_o == live_view
      && view_o.line_keepalive == keepalive_o
      && view_o.request_to_send == rts_o)
    else $error("view lags live state");

  a_rts_and: assert property ( // [RL7]
    past_ok |-> rts_o == ($past(tx_active_i) && $past(cts_s)))
    else $error("send indicator not the AND of its terms");

  a_cmd_drop: assert property ( // [RL8]
    s_timeout ##0 !msg_valid_i |=> cmd == '0 && view_o.blink_mode == 1'b0)
    else $error("commands not dropped on keepalive loss");

  a_timer_restart: assert property ( // [RL9]
    s_ka_msg |=> tick_cnt == 16'h0 && pre_cnt == 32'h0)
    else $error("loss timer not restarted");

endmodule
`default_nettype wire

// file: lkog_pkg.sv
// Constants, register map and carrier types of the keepalive output gate.
package lkog_pkg;

  // Clock period and the fixed loss time base.
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned TICK_NS     = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned LOSS_MS     = 3000;
  localparam int unsigned LOSS_TICKS  = LOSS_MS / TICK_MS;

  // Register byte offsets.
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_VIEW  = 8'h04;
  localparam logic [7:0] ADR_ISTAT = 8'h08;
  localparam logic [7:0] ADR_ICLR  = 8'h0c;
  localparam logic [7:0] ADR_IEN   = 8'h10;

  // Field positions and reset values.
  localparam int unsigned CTRL_MENU = 0;
  localparam int unsigned IRQ_MSG   = 0;
  localparam int unsigned IRQ_GAIN  = 1;
  localparam int unsigned IRQ_LOSS  = 2;
  localparam int unsigned IRQ_W     = 3;
  localparam logic        CTRL_RST  = 1'b0;
  localparam logic [2:0]  IEN_RST   = 3'h0;

  typedef struct packed {
    logic line_keepalive_cmd;
    logic coord_yield_request;
    logic force_off_first;
    logic force_off_second;
    logic demand_all;
    logic plan_release;
    logic walker_demand;
    logic phase_skip_cmd;
    logic uncoord_run;
    logic special_function_one;
    logic special_function_two;
    logic blink_mode;
  } lkog_cmd_t;

  typedef struct packed {
    logic plan_release;
    logic coord_yield_request;
    logic force_off_first;
    logic force_off_second;
    logic phase_skip_cmd;
  } lkog_spec_t;

  typedef struct packed {
    logic line_keepalive;
    logic coord_yield_request;
    logic force_off_first;
    logic force_off_second;
    logic demand_all;
    logic plan_release;
    logic walker_demand;
    logic phase_skip_status;
    logic request_to_send;
    logic carrier_detect;
    logic uncoord_run;
    logic special_function_one;
    logic special_function_two;
    logic blink_mode;
  } lkog_view_t;

endpackage

// file: lkog_central.sv
// Model of the central side that sends keepalive command messages.
`timescale 1ns/10ps
`default_nettype none
module lkog_central
  import lkog_pkg::*;
#(
  parameter int unsigned GAP = 100
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire lkog_cmd_t  cmd_i,
  output logic            msg_valid_o,
  output lkog_cmd_t       msg_cmd_o
);
  logic [15:0] cnt;

  // Idle command lines toggle so stale data never looks like a message.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt         <= 16'h0;
      msg_valid_o <= 1'b0;
      msg_cmd_o   <= '0;
    end
    else if (en_i && cnt == 16'h0)
    begin
      msg_valid_o <= 1'b1;
      msg_cmd_o   <= cmd_i;
      cnt         <= 16'(GAP - 1);
    end
    else
    begin
      msg_valid_o <= 1'b0;
      msg_cmd_o   <= ~msg_cmd_o;
      if (cnt != 16'h0)
        cnt <= cnt - 16'h1;
    end
  end
endmodule
`default_nettype wire

// file: lkog_top_bench.sv
// Self-checking bench for the keepalive output gate.
`timescale 1ns/10ps
`default_nettype none
module lkog_top_bench;
  import lkog_pkg::*;
  localparam int TL = 4;
  logic        clk_i, rst_i, we, cyc, stb, ack, en, tx, cts, cd;
  logic        mv, ka, sb, rts, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dq, q;
  lkog_cmd_t   cmd, mc;
  lkog_spec_t  sp;
  lkog_view_t  vw;
  int          fail_count, cmp_count;

  lkog_top #(.TICK_LEN(TL)) lkog_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr), .dat_i(dat), .dat_o(dq), .we_i(we), .sel_i(sel),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .msg_valid_i(mv),
    .msg_cmd_i(mc), .tx_active_i(tx), .cts_i(cts), .carrier_i(cd),
    .keepalive_o(ka), .spec_o(sp), .standby_o(sb), .rts_o(rts),
    .view_o(vw), .irq_o(irq));
  lkog_central lkog_central_i (.clk_i(clk_i), .rst_i(rst_i), .en_i(en),
    .cmd_i(cmd), .msg_valid_o(mv), .msg_cmd_o(mc));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic lkog_view_t mkv(lkog_cmd_t c, logic r, logic d);
    return {c[11:4], r, d, c[3:0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr <= a;
    we  <= w;
    dat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1);
    // The slave answers one cycle after it first sees the request.
    chk(n, 32'd2);
    q = dq;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  // Waits for the edge at which the design takes a message.
  task automatic await_msg();
    do
      @(posedge clk_i);
    while (mv !== 1'b1);
  endtask

  // Waits for the next message edge, then stops the sender.
  task automatic stop();
    await_msg();
    en <= 1'b0;
  endtask

  task automatic send(input lkog_cmd_t c);
    cmd <= c;
    en  <= 1'b1;
    stop();
  endtask

  task automatic results();
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #(50 * 40000);
    fail_count++;
    $display("mismatch at %0t: timeout", $time);
    results();
  end

  initial
  begin
    {rst_i, we, cyc, stb, en, tx, cts, cd} = 8'h80;
    adr = 8'h0;
    dat = 32'h0;
    sel = 4'h1;
    cmd = '0;
    fail_count = 0;
    cmp_count = 0;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    chk(ka, 1'b0);
    chk(sb, 1'b1);
    chk(sp, 5'h0);
    chk(vw, 14'h0);
    wb(ADR_CTRL, 1'b0, 32'h0);
    chk(q, 32'(CTRL_RST));
    wb(ADR_IEN, 1'b0, 32'h0);
    chk(q, 32'(IEN_RST));
    wb(8'h40, 1'b1, 32'hffffffff);
    wb(8'h40, 1'b0, 32'h0);
    chk(q, 32'h0);
    send(12'h7f0);
    tick(3);
    chk(sp, 5'h0);
    chk(ka, 1'b0);
    chk(irq, 1'b0);
    wb(ADR_IEN, 1'b1, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    wb(ADR_ICLR, 1'b1, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    wb(ADR_IEN, 1'b1, 32'h2);
    cmd <= '1;
    en <= 1'b1;
    await_msg();
    tick(4);
    chk(ka, 1'b1);
    chk(sp, 5'h1f);
    chk(sb, 1'b0);
    chk(irq, 1'b1);
    wb(ADR_ISTAT, 1'b0, 32'h0);
    chk(q, 32'h3);
    wb(ADR_CTRL, 1'b1, 32'h1);
    tx <= 1'b1;
    cts <= 1'b1;
    cd <= 1'b1;
    tick(6);
    wb(ADR_VIEW, 1'b0, 32'h0);
    chk(q, 32'(mkv('1, 1'b1, 1'b1)));
    for (int i = 0; i < 4; i++)
    begin
      tx <= i[1];
      cts <= i[0];
      tick(6);
      chk(rts, i == 3);
      chk(vw, mkv('1, i == 3, 1'b1));
    end
    tick(13000);
    chk(ka, 1'b1);
    stop();
    // Loss falls one tick after the last full loss span.
    tick(TL * (LOSS_TICKS + 1));
    chk(ka, 1'b1);
    tick(1);
    chk(ka, 1'b0);
    chk(sp, 5'h0);
    chk(sb, 1'b1);
    chk(vw, mkv('0, 1'b1, 1'b1));
    wb(ADR_ISTAT, 1'b0, 32'h0);
    chk(q[2], 1'b1);
    wb(ADR_CTRL, 1'b1, 32'h0);
    tick(2);
    chk(vw, 14'h0);
    results();
  end
endmodule
`default_nettype wire
